// *** include/ebrg_pkg.sv ***
// Package for the external bus release and grant block.
// Assumes a single 125 MHz clock domain and active-low memory strobes.
`default_nettype none
package ebrg_pkg;

	// ****************************************
	// Widths and timing
	// ****************************************
	localparam int ADDR_W = 14;
	localparam int DATA_W = 24;
	localparam int CLK_PERIOD_NS = 8;
	// Longest external access, wait states included, in cycles.
	localparam int MAX_ACCESS_CYC = 8;
	localparam logic [3:0] WAIT_MAX = 4'h7;
	localparam logic [3:0] WAIT_ZERO = 4'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_ACCESS = 2'b01,
		ST_GRANT  = 2'b10
	} ebrg_state_t;

	typedef enum logic [1:0] {
		SEL_PROG = 2'b00,
		SEL_DATA = 2'b01,
		SEL_BOOT = 2'b10
	} ebrg_space_t;

	// A request for one external memory access from the core.
	typedef struct packed {
		logic              write;
		ebrg_space_t       space;
		logic [3:0]        waits;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ebrg_acc_req_t;

	// Drive values for the external memory pins; addr_oe, data_oe and ctrl_oe carry the enables.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              prog_mem_select_n;
		logic              data_mem_select_n;
		logic              boot_mem_select_n;
		logic              rd_n;
		logic              wr_n;
	} ebrg_pins_t;

endpackage
`default_nettype wire

// *** test/ebrg_checker.sv ***
// Assertion checker for the bus release and grant block.
// Assumes a bind to ebrg_top and one clock domain.
`default_nettype none
module ebrg_checker (
	input wire logic                 ref_clk,
	input wire logic                 rst_b,
	input wire logic                 bus_request_n,
	input wire logic                 legacy_sync_mode,
	input wire logic                 run_while_granted,
	input wire logic                 acc_valid,
	input wire logic                 boot_active,
	input wire logic                 core_halt,
	input wire logic                 bus_grant_n,
	input wire ebrg_pkg::ebrg_pins_t pins,
	input wire logic                 addr_oe,
	input wire logic                 data_oe,
	input wire logic                 ctrl_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	import ebrg_pkg::*;
	logic [4:0] held_q;
	logic [4:0] held_d;
	// Longest wait is sync plus one full access plus the grant edge.
	always_comb held_d = (bus_request_n || boot_active || !bus_grant_n) ? 5'h0 : held_q + 5'h1;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			held_q <= 5'h0;
		end else begin
			held_q <= held_d;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_float; !bus_grant_n |-> !addr_oe && !ctrl_oe && !data_oe; endproperty
	a_float: assert property (p_float) else $error("driving while granted");
	property p_lat_leg; legacy_sync_mode && $fell(bus_grant_n) |-> !$past(bus_request_n, 1); endproperty
	a_lat_leg: assert property (p_lat_leg) else $error("legacy grant early");
	property p_lat_syn; !legacy_sync_mode && $fell(bus_grant_n) |-> !$past(bus_request_n, 3); endproperty
	a_lat_syn: assert property (p_lat_syn) else $error("grant skips sync");
	property p_busy; !pins.rd_n || !pins.wr_n |-> bus_grant_n && ctrl_oe && addr_oe; endproperty
	a_busy: assert property (p_busy) else $error("grant during access");
	property p_bound; held_q <= 5'(MAX_ACCESS_CYC + 2); endproperty
	a_bound: assert property (p_bound) else $error("grant too late");
	property p_free; (!bus_grant_n && bus_request_n) ##1 bus_request_n [*2] |=> bus_grant_n && addr_oe && ctrl_oe && !core_halt; endproperty
	a_free: assert property (p_free) else $error("no release");
	property p_idle; legacy_sync_mode && !bus_request_n && bus_grant_n && pins.rd_n && pins.wr_n && !acc_valid && !boot_active |=> !bus_grant_n; endproperty
	a_idle: assert property (p_idle) else $error("idle grant late");
	property p_run; (run_while_granted && !bus_grant_n && !acc_valid) [*2] |-> !core_halt; endproperty
	a_run: assert property (p_run) else $error("halted in run mode");
endmodule
bind ebrg_top ebrg_checker ebrg_checker_inst (.ref_clk, .rst_b, .bus_request_n,
	.legacy_sync_mode, .run_while_granted, .acc_valid, .boot_active, .core_halt,
	.bus_grant_n, .pins, .addr_oe, .data_oe, .ctrl_oe);
`default_nettype wire

// *** test/ebrg_master.sv ***
// Model of the external master that borrows the memory buses.
// Assumes the bench raises want while it needs the buses.
`default_nettype none
module ebrg_master (
	input  wire logic ref_clk,
	input  wire logic want,
	output var  logic bus_request_n
);
	timeunit 1ns;
	timeprecision 1ns;
	initial bus_request_n = 1'h1;
	// Request stays low for the whole tenure; the bench uses the buses only once granted.
	always @(posedge ref_clk) bus_request_n <= !want;
endmodule
`default_nettype wire

// *** test/test_ebrg_top.sv ***
// Self-checking bench for the bus release and grant block.
// Assumes the checker and the master model are compiled first.
`default_nettype none
module test_ebrg_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ebrg_pkg::*;
	localparam logic [DATA_W-1:0] MEM = 24'h5a_c396;
	logic ref_clk = 1'h0, rst_b = 1'h0, core_reset_n = 1'h1, legacy_sync_mode = 1'h1;
	logic run_while_granted = 1'h0, acc_valid = 1'h0, boot_active = 1'h0, boot_byte_done = 1'h0;
	logic want = 1'h0, acc_ready, acc_done, core_halt, bus_grant_n, bus_request_n;
	logic addr_oe, data_oe, ctrl_oe;
	logic [DATA_W-1:0] data_in, acc_rdata;
	ebrg_acc_req_t acc_req = '0;
	ebrg_pins_t pins;
	int mismatches = 0, cmp_count = 0, n;
	always #4 ref_clk = ~ref_clk;
	// Released bus shows the inverse so a stale capture is caught.
	assign data_in = (pins.rd_n === 1'h0) ? MEM : ~MEM;
	ebrg_top ebrg_top_inst (.ref_clk, .rst_b, .core_reset_n, .bus_request_n, .legacy_sync_mode,
		.run_while_granted, .acc_valid, .acc_req, .boot_active, .boot_byte_done, .data_in,
		.acc_ready, .acc_done, .acc_rdata, .core_halt, .bus_grant_n, .pins, .addr_oe,
		.data_oe, .ctrl_oe);
	ebrg_master ebrg_master_inst (.ref_clk, .want, .bus_request_n);
	task automatic chk(input bit ok, input string m);
		cmp_count++;
		if (!ok) begin
			mismatches++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic req(input logic v);
		@(posedge ref_clk) want <= v;
		@(posedge ref_clk);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (bus_grant_n !== !v && n < 40);
		chk(bus_grant_n === !v, "grant level");
	endtask
	task automatic acc(input ebrg_space_t sp, input logic w, input logic [3:0] wt);
		int low;
		low = 0;
		@(posedge ref_clk) acc_valid <= 1'h1;
		acc_req <= '{w, sp, wt, 14'h0123, MEM};
		#1;
		for (int i = 0; i < 60 && acc_ready !== 1'h1; i++) @(posedge ref_clk) #1;
		@(posedge ref_clk) acc_valid <= 1'h0;
		#1;
		// Strobes stand from the take edge on, so the first count falls just after it.
		for (int i = 0; i < 12 && acc_done !== 1'h1; i++) begin
			low += ({pins.boot_mem_select_n, pins.data_mem_select_n, pins.prog_mem_select_n,
				pins.rd_n, pins.wr_n, data_oe, pins.addr} === {~(3'h1 << sp), w, !w, w, 14'h0123}
				&& (!w || pins.data === MEM));
			@(posedge ref_clk);
			#1;
		end
		chk(low == wt + 1 && (w || acc_rdata === MEM), "access");
	endtask
	task automatic t_idle;
		for (int m = 1; m >= 0; m--) begin
			@(posedge ref_clk) legacy_sync_mode <= m[0];
			req(1'h1);
			chk(n == 3 - 2 * m && {addr_oe, ctrl_oe, core_halt, acc_ready} === 4'h2, "grant");
			req(1'h0);
			chk(n == 3 - 2 * m && {addr_oe, ctrl_oe, core_halt} === 3'h6, "release");
		end
		$display("idle done");
	endtask
	task automatic t_busy;
		fork
			begin
				acc(SEL_DATA, 1'h0, 4'h7);
				acc(SEL_PROG, 1'h1, 4'h2);
			end
			begin
				step(3);
				req(1'h1);
				chk(n > 4 && acc_ready === 1'h0 && core_halt === 1'h1, "late grant");
				step(5);
				req(1'h0);
			end
		join
		$display("busy done");
	endtask
	task automatic t_boot;
		@(posedge ref_clk) core_reset_n <= 1'h0;
		req(1'h1);
		chk(bus_grant_n === 1'h0, "grant in reset");
		req(1'h0);
		@(posedge ref_clk) core_reset_n <= 1'h1;
		boot_active <= 1'h1;
		acc(SEL_BOOT, 1'h0, 4'h3);
		@(posedge ref_clk) want <= 1'h1;
		step(10);
		#1;
		chk(bus_grant_n === 1'h1, "boot byte");
		@(posedge ref_clk) boot_byte_done <= 1'h1;
		@(posedge ref_clk) boot_byte_done <= 1'h0;
		req(1'h1);
		chk(bus_grant_n === 1'h0, "boot grant");
		req(1'h0);
		@(posedge ref_clk) boot_active <= 1'h0;
		$display("boot done");
	endtask
	task automatic t_run;
		@(posedge ref_clk) run_while_granted <= 1'h1;
		req(1'h1);
		step(2);
		#1;
		chk(core_halt === 1'h0, "run");
		// The stalled access must be the one that runs once the bus comes back.
		fork
			acc(SEL_DATA, 1'h0, 4'h0);
			begin
				step(3);
				#1;
				chk({core_halt, pins.rd_n, acc_ready} === 3'h6, "stall");
				req(1'h0);
			end
		join
		@(posedge ref_clk) run_while_granted <= 1'h0;
		$display("run done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		step(3);
		rst_b <= 1'h1;
		step(2);
		acc(SEL_PROG, 1'h1, 4'h0);
		acc(SEL_BOOT, 1'h0, 4'h7);
		t_idle;
		t_busy;
		t_boot;
		t_run;
		final_report;
	end
	initial begin
		#20000;
		mismatches++;
		final_report;
	end
endmodule
`default_nettype wire

// *** verilog/ebrg_req_sync.sv ***
// Two-stage synchroniser for the asynchronous bus request pin.
// Assumes the pin is sampled by ref_clk; legacy mode bypasses both stages.
`default_nettype none
module ebrg_req_sync (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic async_in_n,
	output var  logic sync_out_n
);
	import ebrg_pkg::*;

	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	always_comb begin
		meta_d = async_in_n;
		sync_d = meta_q;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out_n = sync_q;
endmodule
`default_nettype wire

// *** verilog/ebrg_top.sv ***
// External bus release and grant logic of the processor's memory interface.
// Assumes the core issues one external access at a time and obeys the halt output.
// Contract
// R01: Idle request: next cycle float, grant, halt.
// R02: Run mode keeps executing until external access.
// R03: Busy request: grant after access completes.
// R04: Grant allowed between accesses of one instruction.
// R05: Request withdrawn: ungrant, drive, resume in place.
// R06: Requests honoured during boot and reset.
// R07: Request asynchronous; grant one cycle after recognition.
// R08: Boot: grant only after current byte loaded.
// R09: Master holds request; waits for grant.
`default_nettype none
module ebrg_top (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_b,
	input  wire logic                   core_reset_n,
	input  wire logic                   bus_request_n,
	input  wire logic                   legacy_sync_mode,
	input  wire logic                   run_while_granted,
	input  wire logic                   acc_valid,
	input  wire ebrg_pkg::ebrg_acc_req_t acc_req,
	input  wire logic                   boot_active,
	input  wire logic                   boot_byte_done,
	input  wire logic [ebrg_pkg::DATA_W-1:0] data_in,
	output logic                        acc_ready,
	output var  logic                   acc_done,
	output var  logic [ebrg_pkg::DATA_W-1:0] acc_rdata,
	output var  logic                   core_halt,
	output var  logic                   bus_grant_n,
	output var  ebrg_pkg::ebrg_pins_t   pins,
	output var  logic                   addr_oe,
	output var  logic                   data_oe,
	output var  logic                   ctrl_oe
);
	import ebrg_pkg::*;

	// ****************************************
	// Request recognition
	// ****************************************
	logic req_sync_n;
	logic req_seen;

	// The asynchronous path costs two cycles of latency; legacy parts take the pin as is.
	ebrg_req_sync u_req_sync (
		.ref_clk    (ref_clk),
		.rst_b      (rst_b),
		.async_in_n (bus_request_n),
		.sync_out_n (req_sync_n)
	);

	always_comb begin
		req_seen = legacy_sync_mode ? !bus_request_n : !req_sync_n; // R07
	end

	// ****************************************
	// Access and grant sequencer
	// ****************************************
	ebrg_state_t       state_q;
	ebrg_state_t       state_d;
	logic [3:0]        wait_q;
	logic [3:0]        wait_d;
	ebrg_acc_req_t     cur_q;
	ebrg_acc_req_t     cur_d;
	logic              done_d;
	logic [DATA_W-1:0] rdata_d;
	logic              grant_now;
	logic              boot_block_q;
	logic              boot_block_d;

	// A boot byte in flight holds the grant off until the loader marks it complete.
	// A new boot byte taken in the cycle that the previous one completes must still block.
	always_comb begin
		boot_block_d = boot_block_q;
		if (boot_byte_done || !boot_active) begin
			boot_block_d = 1'b0; // R08
		end
		if (boot_active && acc_valid && acc_ready && (acc_req.space == SEL_BOOT)) begin
			boot_block_d = 1'b1; // R08
		end
	end

	// Core reset does not gate this path, so the bus is released even in reset.
	always_comb begin
		grant_now = req_seen && !boot_block_q; // R06 R08
	end

	always_comb begin
		state_d = state_q;
		wait_d  = wait_q;
		cur_d   = cur_q;
		done_d  = 1'b0;
		rdata_d = acc_rdata;
		case (state_q)
			ST_IDLE: begin
				if (grant_now) begin
					state_d = ST_GRANT; // R01
				end else if (acc_valid && core_reset_n) begin
					state_d = ST_ACCESS;
					cur_d   = acc_req;
					wait_d  = (acc_req.waits > WAIT_MAX) ? WAIT_MAX : acc_req.waits;
				end
			end
			ST_ACCESS: begin
				if (wait_q == WAIT_ZERO) begin
					done_d  = 1'b1;
					rdata_d = data_in;
					// The bus goes only after the last wait state, never mid-access.
					state_d = grant_now ? ST_GRANT : ST_IDLE; // R03 R04
				end else begin
					wait_d = wait_q - 4'h1;
				end
			end
			ST_GRANT: begin
				if (!req_seen) begin
					state_d = ST_IDLE; // R05
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q      <= ST_IDLE;
			wait_q       <= WAIT_ZERO;
			cur_q        <= '0;
			acc_done     <= 1'b0;
			acc_rdata    <= '0;
			boot_block_q <= 1'b0;
		end else begin
			state_q      <= state_d;
			wait_q       <= wait_d;
			cur_q        <= cur_d;
			acc_done     <= done_d;
			acc_rdata    <= rdata_d;
			boot_block_q <= boot_block_d;
		end
	end

	// ****************************************
	// Core handshake
	// ****************************************
	// A new access is only taken when idle and no grant is pending this cycle.
	always_comb begin
		acc_ready = (state_q == ST_IDLE) && !grant_now && core_reset_n;
	end

	// Halt stays on until the access that the core wants can run, or the bus comes back.
	logic halt_d;
	// Halt follows the next state so that it moves on the same edge as the grant.
	always_comb begin
		if (state_d == ST_GRANT) begin
			halt_d = run_while_granted ? acc_valid : 1'b1; // R01 R02
		end else begin
			halt_d = 1'b0; // R05
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	ebrg_pins_t pins_d;
	logic       oe_d;

	always_comb begin
		pins_d.addr              = cur_q.addr;
		pins_d.data              = cur_q.wdata;
		pins_d.prog_mem_select_n = 1'b1;
		pins_d.data_mem_select_n = 1'b1;
		pins_d.boot_mem_select_n = 1'b1;
		pins_d.rd_n              = 1'b1;
		pins_d.wr_n              = 1'b1;
		if (state_d == ST_ACCESS) begin
			pins_d.addr = cur_d.addr;
			pins_d.data = cur_d.wdata;
			pins_d.prog_mem_select_n = !(cur_d.space == SEL_PROG);
			pins_d.data_mem_select_n = !(cur_d.space == SEL_DATA);
			pins_d.boot_mem_select_n = !(cur_d.space == SEL_BOOT);
			pins_d.rd_n = cur_d.write;
			pins_d.wr_n = !cur_d.write;
		end
		oe_d = (state_d != ST_GRANT); // R01 R05
	end

	logic data_oe_d;
	always_comb begin
		data_oe_d = (state_d == ST_ACCESS) && cur_d.write;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pins        <= '1;
			addr_oe     <= 1'b1;
			ctrl_oe     <= 1'b1;
			data_oe     <= 1'b0;
			bus_grant_n <= 1'b1;
			core_halt   <= 1'b0;
		end else begin
			pins        <= pins_d;
			addr_oe     <= oe_d;
			ctrl_oe     <= oe_d;
			data_oe     <= data_oe_d;
			bus_grant_n <= oe_d; // R07
			core_halt   <= halt_d;
		end
	end

endmodule
`default_nettype wire
